//--- dos_pkg.sv
package dos_pkg;

  // Register byte offsets on the APB slave
  localparam logic [11:0] DOS_OFF_DAC = 12'h000;
  localparam logic [11:0] DOS_OFF_CTRL = 12'h004;
  localparam logic [11:0] DOS_OFF_CLRCODE = 12'h008;
  localparam logic [11:0] DOS_OFF_SWCTL = 12'h00C;
  localparam logic [11:0] DOS_OFF_STATUS = 12'h010;

  // Converter width
  localparam int DOS_CODE_W = 18;
  localparam int DOS_MSB = DOS_CODE_W - 1;

  // Control register field positions
  localparam int DOS_CTRL_FBSEL = 1;
  localparam int DOS_CTRL_TRI = 2;
  localparam int DOS_CTRL_CLAMP = 3;
  localparam int DOS_CTRL_OFFBIN = 4;

  // Software control register bit positions
  localparam int DOS_SW_LOAD = 0;
  localparam int DOS_SW_CLEAR = 1;
  localparam int DOS_SW_RESET = 2;

  // Status register field positions
  localparam int DOS_ST_STATE = 18;
  localparam int DOS_ST_LOADPIN = 21;
  localparam int DOS_ST_CLRPIN = 22;

  // Reset values
  localparam logic DOS_RST_FBSEL = 1'b0;
  localparam logic DOS_RST_TRI = 1'b1;
  localparam logic DOS_RST_CLAMP = 1'b1;
  localparam logic DOS_RST_OFFBIN = 1'b0;
  // Twos complement code of the most negative value: negative reference
  localparam logic [17:0] DOS_RST_DAC = 18'h20000;
  localparam logic [17:0] DOS_RST_CLRCODE = 18'h00000;
  // Offset binary zero drives the negative reference
  localparam logic [17:0] DOS_RST_OUT = 18'h00000;

  // Control register fields
  typedef struct packed {
    logic offset_binary;
    logic output_clamp_bit;
    logic output_tristate_bit;
    logic feedback_resistor_select;
  } dos_ctrl_s;

  localparam dos_ctrl_s DOS_RST_CTRL = '{
    offset_binary: DOS_RST_OFFBIN,
    output_clamp_bit: DOS_RST_CLAMP,
    output_tristate_bit: DOS_RST_TRI,
    feedback_resistor_select: DOS_RST_FBSEL
  };

  // Output state of the converter, one-hot
  typedef enum logic [2:0] {
    DOS_OS_NORMAL = 3'b001,
    DOS_OS_CLAMP = 3'b010,
    DOS_OS_TRI = 3'b100
  } dos_state_e;

  // What the analog core sees
  typedef struct packed {
    dos_state_e state;
    logic feedback_resistor_select;
    logic [17:0] code;
  } dos_out_s;

endpackage

//--- dos_ctrl.sv
`timescale 1ns/1ps

// Overview of operation
// - Writing software reset bit as 1 returns all registers and output to power-on.
// - Software load request is ignored while the clear_to_code pin is low.
// - Power-on reset puts every register at its default value.
// - After power-on the output is tristate and clamped to ground.
// - Tristate and clamp hold until the host rewrites the control register.
// - With both cleared, output sits at negative reference unless reprogrammed.
// - Clamp wins; tristate alone gives tristate; both clear gives normal.
// - Tristate bit resets to 1; writing 0 with clamp also 0 selects normal operation.
module dos_ctrl (
  input wire logic pclk, // 250 MHz bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic load_update_n, // Load pin, active low
  input wire logic clear_to_code_n, // Clear pin, active low
  output dos_pkg::dos_out_s dac_out // State and code for analog core
);
  import dos_pkg::*;

  dos_ctrl_s ctrl_r, ctrl_nxt;
  logic [17:0] dac_r, dac_nxt;
  logic [17:0] clr_code_r, clr_code_nxt;
  logic [17:0] out_code_r, out_code_nxt;
  dos_state_e state_r, state_nxt;
  logic [31:0] prdata_r, prdata_nxt;

  logic setup_rd;
  logic acc_wr;
  logic mapped;
  logic sw_load;
  logic sw_clear;
  logic sw_reset;
  logic do_clear;
  logic do_load;

  // Output code in offset binary, the format of the resistor string
  function automatic logic [17:0] to_offbin(input logic [17:0] v,
                                            input logic offbin);
    logic [17:0] r;
    r = v;
    if (!offbin) begin
      r[DOS_MSB] = ~v[DOS_MSB];
    end
    return r;
  endfunction

  // Output state decode; clamp overrides tristate
  function automatic dos_state_e decode(input dos_ctrl_s c);
    dos_state_e s;
    if (c.output_clamp_bit) begin
      s = DOS_OS_CLAMP;
    end else if (c.output_tristate_bit) begin
      s = DOS_OS_TRI;
    end else begin
      s = DOS_OS_NORMAL;
    end
    return s;
  endfunction

  logic hit_dac;
  logic hit_ctrl;
  logic hit_clr;
  logic hit_sw;
  logic hit_status;
  logic wr_dac;
  logic wr_ctrl;
  logic wr_clr;
  logic [17:0] wdata_code;
  dos_ctrl_s wdata_ctrl;
  logic [31:0] view_dac;
  logic [31:0] view_ctrl;
  logic [31:0] view_clr;
  logic [31:0] view_status;
  logic [31:0] rd_word;

  // One hit per register
  // Full compare, so aliased addresses stay unmapped
  always_comb begin
    hit_dac = (paddr == DOS_OFF_DAC);
    hit_ctrl = (paddr == DOS_OFF_CTRL);
    hit_clr = (paddr == DOS_OFF_CLRCODE);
    hit_sw = (paddr == DOS_OFF_SWCTL);
    hit_status = (paddr == DOS_OFF_STATUS);
  end

  // Transfer phases; no wait states while enabled
  always_comb begin
    mapped = hit_dac || hit_ctrl || hit_clr || hit_sw || hit_status;
    setup_rd = psel && !penable && !pwrite;
    acc_wr = psel && penable && pwrite && mapped;
  end

  // Handshake; stalled bus follows the frozen clock enable
  assign pready = ce;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;

  // Write strobes; status is read-only and ignores writes
  // Software control bits are strobes, never stored
  always_comb begin
    wr_dac = acc_wr && hit_dac;
    wr_ctrl = acc_wr && hit_ctrl;
    wr_clr = acc_wr && hit_clr;
    sw_load = acc_wr && hit_sw && pwdata[DOS_SW_LOAD];
    sw_clear = acc_wr && hit_sw && pwdata[DOS_SW_CLEAR];
    sw_reset = acc_wr && hit_sw && pwdata[DOS_SW_RESET];
  end

  // Write data split into register fields
  always_comb begin
    wdata_code = pwdata[DOS_MSB:0];
    wdata_ctrl.feedback_resistor_select = pwdata[DOS_CTRL_FBSEL];
    wdata_ctrl.output_tristate_bit = pwdata[DOS_CTRL_TRI];
    wdata_ctrl.output_clamp_bit = pwdata[DOS_CTRL_CLAMP];
    wdata_ctrl.offset_binary = pwdata[DOS_CTRL_OFFBIN];
  end

  // Pins act like held soft strobes; clear pin beats every load
  // Soft clear is ignored while the load pin is held low
  always_comb begin
    do_clear = !clear_to_code_n || (sw_clear && load_update_n);
    do_load = (!load_update_n || sw_load) && clear_to_code_n;
  end

  // Control register; tristate and clamp leave power-on only here
  // Soft reset beats a same-cycle write
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (sw_reset) begin
      ctrl_nxt = DOS_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_nxt = wdata_ctrl;
    end
  end

  // Control register state; power-on is tristate and clamped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= DOS_RST_CTRL;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Input register; a clear overwrites a same-cycle host write
  always_comb begin
    dac_nxt = dac_r;
    if (sw_reset) begin
      dac_nxt = DOS_RST_DAC;
    end else if (do_clear) begin
      dac_nxt = clr_code_nxt;
    end else if (wr_dac) begin
      dac_nxt = wdata_code;
    end
  end

  // Input register state; reset value maps to negative reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_r <= DOS_RST_DAC;
    end else if (ce) begin
      dac_r <= dac_nxt;
    end
  end

  // Clear code register
  always_comb begin
    clr_code_nxt = clr_code_r;
    if (sw_reset) begin
      clr_code_nxt = DOS_RST_CLRCODE;
    end else if (wr_clr) begin
      clr_code_nxt = wdata_code;
    end
  end

  // Clear code register state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_code_r <= DOS_RST_CLRCODE;
    end else if (ce) begin
      clr_code_r <= clr_code_nxt;
    end
  end

  // Output code; loads convert with the coding of the same cycle
  // A held load pin lets a same-cycle write pass straight through
  always_comb begin
    out_code_nxt = out_code_r;
    if (sw_reset) begin
      out_code_nxt = DOS_RST_OUT;
    end else if (do_clear) begin
      out_code_nxt = to_offbin(clr_code_nxt, ctrl_nxt.offset_binary);
    end else if (do_load) begin
      out_code_nxt = to_offbin(dac_nxt, ctrl_nxt.offset_binary);
    end
  end

  // Output code state; zero is the negative reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_code_r <= DOS_RST_OUT;
    end else if (ce) begin
      out_code_r <= out_code_nxt;
    end
  end

  // Output state follows the control bits of the same edge
  // Registered so the analog switches never see decode glitches
  always_comb begin
    state_nxt = decode(ctrl_nxt);
  end

  // Output state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= DOS_OS_CLAMP;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Read view of the input register
  always_comb begin
    view_dac = 32'h00000000;
    view_dac[DOS_MSB:0] = dac_r;
  end

  // Read view of the control register
  always_comb begin
    view_ctrl = 32'h00000000;
    view_ctrl[DOS_CTRL_FBSEL] = ctrl_r.feedback_resistor_select;
    view_ctrl[DOS_CTRL_TRI] = ctrl_r.output_tristate_bit;
    view_ctrl[DOS_CTRL_CLAMP] = ctrl_r.output_clamp_bit;
    view_ctrl[DOS_CTRL_OFFBIN] = ctrl_r.offset_binary;
  end

  // Read view of the clear code register
  always_comb begin
    view_clr = 32'h00000000;
    view_clr[DOS_MSB:0] = clr_code_r;
  end

  // Status view; pins shown raw for board debug
  always_comb begin
    view_status = 32'h00000000;
    view_status[DOS_MSB:0] = out_code_r;
    view_status[DOS_ST_STATE +: 3] = state_r;
    view_status[DOS_ST_LOADPIN] = load_update_n;
    view_status[DOS_ST_CLRPIN] = clear_to_code_n;
  end

  // Read mux; write-only and unmapped addresses read zero
  always_comb begin
    unique case (paddr)
      DOS_OFF_DAC: rd_word = view_dac;
      DOS_OFF_CTRL: rd_word = view_ctrl;
      DOS_OFF_CLRCODE: rd_word = view_clr;
      DOS_OFF_STATUS: rd_word = view_status;
      default: rd_word = 32'h00000000;
    endcase
  end

  // Read data captured in setup, presented in access
  // Costs a flop stage but keeps prdata off the address path
  always_comb begin
    prdata_nxt = prdata_r;
    if (setup_rd) begin
      prdata_nxt = rd_word;
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (ce) begin
      prdata_r <= prdata_nxt;
    end
  end

  // Outputs straight from flip-flops
  always_comb begin
    dac_out.state = state_r;
    dac_out.feedback_resistor_select = ctrl_r.feedback_resistor_select;
    dac_out.code = out_code_r;
  end

endmodule

//--- dos_chk.sv
`timescale 1ns/1ps
module dos_chk (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low
  input wire logic ce, // Enable
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Wdata
  input wire logic [31:0] prdata, // Rdata
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic load_update_n, // Load pin
  input wire logic clear_to_code_n, // Clear pin
  input wire dos_pkg::dos_out_s dac_out // Core
);
  import dos_pkg::*;
  logic wr, sw, ct;
  // Completed writes, by target
  assign wr = psel && penable && pwrite && ce;
  assign sw = wr && paddr == DOS_OFF_SWCTL;
  assign ct = wr && paddr == DOS_OFF_CTRL;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SOFT_RESET: assert property (sw && pwdata[DOS_SW_RESET] |=>
    dac_out.state == DOS_OS_CLAMP && dac_out.code == DOS_RST_OUT)
    else $error("soft reset did not restore output");
  AST_CLEAR_HOLD: assert property (
    (!clear_to_code_n && ce && !wr) [*2] |=> $stable(dac_out.code))
    else $error("output moved while clear pin low");
  AST_POR_CODE: assert property ($rose(presetn) |->
    dac_out.code == DOS_RST_OUT && prdata == 32'h00000000)
    else $error("register not at default after reset");
  AST_POR_CLAMP: assert property (
    $rose(presetn) |-> dac_out.state == DOS_OS_CLAMP)
    else $error("output not clamped after reset");
  AST_STATE_HOLD: assert property (
    !$past(ct || sw) |-> $stable(dac_out.state))
    else $error("state changed without control write");
  AST_DECODE: assert property (ct |=> dac_out.state ==
    ($past(pwdata[DOS_CTRL_CLAMP]) ? DOS_OS_CLAMP :
    $past(pwdata[DOS_CTRL_TRI]) ? DOS_OS_TRI : DOS_OS_NORMAL))
    else $error("output state decode wrong");
  AST_FB_SEL: assert property (ct |=>
    dac_out.feedback_resistor_select == $past(pwdata[DOS_CTRL_FBSEL]))
    else $error("feedback select not taken");
  AST_NORMAL: assert property (ct && !pwdata[DOS_CTRL_TRI] &&
    !pwdata[DOS_CTRL_CLAMP] |=> dac_out.state == DOS_OS_NORMAL)
    else $error("normal mode not entered");
endmodule
bind dos_ctrl dos_chk chk_i (.*);

//--- dos_host.sv
`timescale 1ns/1ps
module dos_host (
  input wire logic pclk, // Clock
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [31:0] prdata, // Rdata
  output logic psel, // Select
  output logic penable, // Access
  output logic pwrite, // Direction
  output logic [11:0] paddr, // Address
  output logic [31:0] pwdata // Wdata
);
  // Idle bus from time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // One transfer; bounded wait so a dead slave cannot hang the run
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e,
    output logic to);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    q = prdata;
    e = pslverr;
    to = n >= 64;
    {psel, penable} <= 2'b00;
  endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dos_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, e, to;
  logic load_update_n, clear_to_code_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, v;
  logic [17:0] c, d;
  dos_out_s dac_out;
  int fails, tests_run, seed;
  dos_ctrl uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .load_update_n(load_update_n), .clear_to_code_n(clear_to_code_n),
    .dac_out(dac_out));
  dos_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  // 4 ns bus clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Clamp wins over tristate
  function automatic logic [2:0] exp_st(input logic [31:0] w);
    return w[DOS_CTRL_CLAMP] ? DOS_OS_CLAMP :
      w[DOS_CTRL_TRI] ? DOS_OS_TRI : DOS_OS_NORMAL;
  endfunction
  task automatic end_sim();
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, g);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, x, g);
    end
  endtask
  // Bus access; a hung slave ends the run
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] t);
    host.xfer(w, a, t, q, e, to);
    if (to !== 1'b0) begin
      fails++;
      end_sim();
    end
  endtask
  initial begin
    {seed, fails, tests_run} = {32'd99, 32'd0, 32'd0};
    {ce, presetn, load_update_n, clear_to_code_n} = 4'b1011;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    bus(0, DOS_OFF_STATUS, 0);
    chk("rst_out", {DOS_OS_CLAMP, DOS_RST_OUT}, q[20:0]);
    bus(0, DOS_OFF_CTRL, 0);
    chk("rst_ctrl", 32'h0000000C, q);
    d = 18'($random(seed));
    bus(1, DOS_OFF_DAC, {14'h0, d});
    bus(0, DOS_OFF_STATUS, 0);
    chk("hold", DOS_OS_CLAMP, q[20:18]);
    // Every tristate and clamp pairing, random feedback select
    for (int i = 0; i < 8; i++) begin
      v = {28'h0, 2'(i), 1'($random(seed)), 1'b0};
      bus(1, DOS_OFF_CTRL, v);
      bus(0, DOS_OFF_STATUS, 0);
      chk("state", exp_st(v), q[20:18]);
      chk("fbsel", {31'h0, v[1]},
        {31'h0, dac_out.feedback_resistor_select});
    end
    bus(1, DOS_OFF_CTRL, 0);
    bus(0, DOS_OFF_STATUS, 0);
    chk("neg_ref", {DOS_OS_NORMAL, DOS_RST_OUT}, q[20:0]);
    c = 18'($random(seed));
    bus(1, DOS_OFF_CLRCODE, {14'h0, c});
    clear_to_code_n <= 1'b0;
    bus(1, DOS_OFF_SWCTL, 32'h1);
    bus(0, DOS_OFF_STATUS, 0);
    chk("clr_code", c ^ 18'h20000, q[17:0]);
    clear_to_code_n <= 1'b1;
    bus(1, DOS_OFF_DAC, {14'h0, d});
    bus(1, DOS_OFF_SWCTL, 32'h1);
    bus(0, DOS_OFF_STATUS, 0);
    chk("load", d ^ 18'h20000, q[17:0]);
    // Offset binary passes codes through; held load pin tracks writes
    bus(1, DOS_OFF_CTRL, 32'h00000010);
    load_update_n <= 1'b0;
    d = 18'($random(seed));
    bus(1, DOS_OFF_DAC, {14'h0, d});
    bus(0, DOS_OFF_STATUS, 0);
    chk("pin_load", {2'b10, DOS_OS_NORMAL, d}, q[22:0]);
    bus(1, DOS_OFF_SWCTL, 32'h2);
    bus(0, DOS_OFF_STATUS, 0);
    chk("clr_blocked", {14'h0, d}, q[17:0]);
    load_update_n <= 1'b1;
    bus(1, DOS_OFF_SWCTL, 32'h2);
    bus(0, DOS_OFF_STATUS, 0);
    chk("soft_clr", {2'b11, DOS_OS_NORMAL, c}, q[22:0]);
    bus(0, 12'hFF0, 0);
    chk("unmapped", 32'h1, {31'h0, e});
    bus(1, DOS_OFF_SWCTL, 32'h4);
    bus(0, DOS_OFF_STATUS, 0);
    chk("sw_rst", {DOS_OS_CLAMP, DOS_RST_OUT}, q[20:0]);
    bus(0, DOS_OFF_CTRL, 0);
    chk("sw_rst_ctrl", 32'h0000000C, q);
    // Mid-run hardware reset
    bus(1, DOS_OFF_CTRL, 32'h00000002);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    bus(0, DOS_OFF_CTRL, 0);
    chk("por_ctrl", 32'h0000000C, q);
    chk("por_fb", 32'h0,
      {31'h0, dac_out.feedback_resistor_select});
    end_sim();
  end
endmodule
